// File: rtc_tod.sv
// Time-of-day counter chain with its AXI4-Lite register slave.
// Assumes month and year come from the date logic; day carry goes back to it.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module rtc_tod (
  input logic mclk,             // 100 MHz clock
  input logic arst_n,           // Async reset, active low
  input logic awvalid,          // Write address valid
  output logic awready,         // Write address ready
  input logic [31:0] awaddr,    // Write byte address
  input logic wvalid,           // Write data valid
  output logic wready,          // Write data ready
  input logic [31:0] wdata,     // Write data
  input logic [3:0] wstrb,      // Byte enables
  output logic bvalid,          // Write response valid
  input logic bready,           // Write response ready
  output logic [1:0] bresp,     // Write response
  input logic arvalid,          // Read address valid
  output logic arready,         // Read address ready
  input logic [31:0] araddr,    // Read byte address
  output logic rvalid,          // Read data valid
  input logic rready,           // Read data ready
  output logic [31:0] rdata,    // Read data
  output logic [1:0] rresp,     // Read response
  input logic [7:0] monthBcd,   // Current month, BCD
  input logic [7:0] yearBcd,    // Current year, BCD
  output logic dayCarry,        // Pulse when the day wraps
  output logic clockFormat24h,  // Hour format, 1 = 24-hour
  output logic counterRunEnable, // Chain running
  output logic countHoldAck     // Counters held for access
);
  import rtc_pkg::*;

  rtc_time_s time_reg;
  logic [15:0] presc_reg;
  logic [7:0] wrBuf_reg;
  rtc_sel_e wrSel_reg;
  logic pendOvf_reg, holdReq_reg, holdAck_reg, fmt24_reg, run_reg, wrPend_reg, dayCarry_reg;

  logic [31:0] awAddr_reg, wData_reg, rdata_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic awready_reg, wready_reg, wLow_reg, bvalid_reg, arready_reg, rvalid_reg;

  rtc_sel_e wrSel, rdSel;
  logic wrFire, ovf, secTick, secCarry, minCarry, hourCarry, fmtWrite;
  logic ldSec, ldMin, ldHour, ldWeek, ldDay;
  logic [7:0] secNext, minNext, weekNext, dayNext, hourNext, hourAs24, hourAs12, dayMax;
  logic secWrap, minWrap, weekWrap, dayWrap, hourWrap;

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign dayCarry = dayCarry_reg;
  assign clockFormat24h = fmt24_reg;
  assign counterRunEnable = run_reg;
  assign countHoldAck = holdAck_reg;

  // Write channel: address and data taken in either order, answered together
  assign wrFire = !awready_reg && !wready_reg && !bvalid_reg;
  assign wrSel = rtcSel(awAddr_reg);
  assign rdSel = rtcSel(araddr);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awready_reg <= 1'b1;
      awAddr_reg <= 32'h0;
    end else if (awvalid && awready_reg) begin
      awready_reg <= 1'b0;
      awAddr_reg <= awaddr;
    end else if (wrFire) begin
      awready_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wready_reg <= 1'b1;
      wData_reg <= 32'h0;
      wLow_reg <= 1'b0;
    end else if (wvalid && wready_reg) begin
      wready_reg <= 1'b0;
      wData_reg <= wdata;
      wLow_reg <= wstrb[0];
    end else if (wrFire) begin
      wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wrFire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= (rdSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      rdata_reg <= 32'h0;
      unique case (rdSel)
        SEL_SEC: rdata_reg[7:0] <= time_reg.sec;
        SEL_MIN: rdata_reg[7:0] <= time_reg.min;
        SEL_HOUR: rdata_reg[7:0] <= time_reg.hour;
        SEL_WEEK: rdata_reg[7:0] <= time_reg.week;
        SEL_DAY: rdata_reg[7:0] <= time_reg.day;
        SEL_CTL: begin
          rdata_reg[CTL_FMT_BIT] <= fmt24_reg;
          rdata_reg[CTL_RUN_BIT] <= run_reg;
        end
        SEL_HOLD: begin
          rdata_reg[HOLD_REQ_BIT] <= holdReq_reg;
          rdata_reg[HOLD_ACK_BIT] <= holdAck_reg;
        end
        SEL_NONE: rdata_reg <= 32'h0;
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Control and hold bits
  assign fmtWrite = wrFire && wLow_reg && wrSel == SEL_CTL;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fmt24_reg <= 1'b0;
      run_reg <= 1'b0;
    end else if (fmtWrite) begin
      fmt24_reg <= wData_reg[CTL_FMT_BIT];
      run_reg <= wData_reg[CTL_RUN_BIT];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      holdReq_reg <= 1'b0;
    end else if (wrFire && wLow_reg && wrSel == SEL_HOLD) begin
      holdReq_reg <= wData_reg[HOLD_REQ_BIT];
    end
  end

  // Acknowledge trails the request by one clock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      holdAck_reg <= 1'b0;
    end else begin
      holdAck_reg <= holdReq_reg;
    end
  end

  // Write buffer: software data reaches the counter two clocks after the write
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_reg <= 1'b0;
      wrBuf_reg <= 8'h00;
      wrSel_reg <= SEL_NONE;
    end else if (wrFire && wLow_reg && wrSel <= SEL_DAY) begin
      wrPend_reg <= 1'b1;
      wrBuf_reg <= wData_reg[7:0];
      wrSel_reg <= wrSel;
    end else begin
      wrPend_reg <= 1'b0;
    end
  end

  assign ldSec = wrPend_reg && wrSel_reg == SEL_SEC;
  assign ldMin = wrPend_reg && wrSel_reg == SEL_MIN;
  assign ldHour = wrPend_reg && wrSel_reg == SEL_HOUR;
  assign ldWeek = wrPend_reg && wrSel_reg == SEL_WEEK;
  assign ldDay = wrPend_reg && wrSel_reg == SEL_DAY;

  // Prescaler keeps running through a hold
  assign ovf = run_reg && presc_reg == PRESC_MAX;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      presc_reg <= 16'h0000;
    end else if (ldSec) begin
      presc_reg <= 16'h0000;
    end else if (run_reg) begin
      presc_reg <= 16'(presc_reg + 16'h0001);
    end
  end

  // A seconds write discards a remembered overflow
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pendOvf_reg <= 1'b0;
    end else if (ldSec) begin
      pendOvf_reg <= 1'b0;
    end else if (ovf && holdReq_reg) begin
      pendOvf_reg <= 1'b1;
    end else if (!holdReq_reg) begin
      pendOvf_reg <= 1'b0;
    end
  end

  assign secTick = run_reg && !holdReq_reg && (ovf || pendOvf_reg);
  assign secCarry = secTick && secWrap;
  assign minCarry = secCarry && minWrap && !ldMin;
  assign hourCarry = minCarry && hourWrap && !ldHour;
  assign dayMax = rtcDayMax(monthBcd, yearBcd);

  rtc_bcd_step secStep (
    .valIn(time_reg.sec),
    .maxVal(SEC_MAX),
    .minVal(BCD_ZERO),
    .valNext(secNext),
    .atMax(secWrap)
  );

  rtc_bcd_step minStep (
    .valIn(time_reg.min),
    .maxVal(MIN_MAX),
    .minVal(BCD_ZERO),
    .valNext(minNext),
    .atMax(minWrap)
  );

  rtc_bcd_step dayStep (
    .valIn(time_reg.day),
    .maxVal(dayMax),
    .minVal(DAY_MIN),
    .valNext(dayNext),
    .atMax(dayWrap)
  );

  rtc_bcd_step weekStep (
    .valIn(time_reg.week),
    .maxVal(WEEK_MAX),
    .minVal(BCD_ZERO),
    .valNext(weekNext),
    .atMax(weekWrap)
  );

  rtc_hour_conv hourCalc (
    .hourIn(time_reg.hour),
    .fmt24(fmt24_reg),
    .as24(hourAs24),
    .as12(hourAs12),
    .hourNext(hourNext),
    .atLast(hourWrap)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      time_reg.sec <= RST_SEC;
    end else if (ldSec) begin
      time_reg.sec <= wrBuf_reg;
    end else if (secTick) begin
      time_reg.sec <= secNext;
    end
  end

  // Written value beats a carry on the same edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      time_reg.min <= RST_MIN;
    end else if (ldMin) begin
      time_reg.min <= wrBuf_reg;
    end else if (secCarry) begin
      time_reg.min <= minNext;
    end
  end

  // Format change rewrites the hour in the new code
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      time_reg.hour <= RST_HOUR;
    end else if (ldHour) begin
      time_reg.hour <= wrBuf_reg;
    end else if (fmtWrite && wData_reg[CTL_FMT_BIT] != fmt24_reg) begin
      time_reg.hour <= wData_reg[CTL_FMT_BIT] ? hourAs24 : hourAs12;
    end else if (minCarry) begin
      time_reg.hour <= hourNext;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      time_reg.day <= RST_DAY;
    end else if (ldDay) begin
      time_reg.day <= wrBuf_reg;
    end else if (hourCarry) begin
      time_reg.day <= dayNext;
    end
  end

  // No date-derived weekday; it just follows the day step
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      time_reg.week <= RST_WEEK;
    end else if (ldWeek) begin
      time_reg.week <= wrBuf_reg;
    end else if (hourCarry) begin
      time_reg.week <= weekNext;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dayCarry_reg <= 1'b0;
    end else begin
      dayCarry_reg <= hourCarry && dayWrap && !ldDay;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_sec_wrap_chain: assert property (
    secTick && time_reg.sec == SEC_MAX && !ldSec && !ldMin
    |=> time_reg.sec == BCD_ZERO && time_reg.min != $past(time_reg.min))
    else $error("seconds wrap did not advance minutes");

  a_write_lands: assert property (
    wrFire && wLow_reg && wrSel == SEL_SEC |-> ##2 time_reg.sec == $past(wData_reg[7:0], 2))
    else $error("seconds write not in counter two clocks later");

  a_presc_clear: assert property (
    ldSec |=> presc_reg == 16'h0000 && !pendOvf_reg)
    else $error("seconds write did not clear prescaler");

  a_write_wins: assert property (
    ldMin |=> time_reg.min == $past(wrBuf_reg))
    else $error("carry beat a minutes write");

  a_hold_ack: assert property (
    $rose(holdReq_reg) |=> countHoldAck ##1 countHoldAck || !holdReq_reg)
    else $error("hold acknowledge late");

  a_held_frozen: assert property (
    holdReq_reg && !wrPend_reg && !fmtWrite |=> $stable(time_reg))
    else $error("counters moved during hold");

  a_to24_midnight: assert property (
    fmtWrite && wData_reg[CTL_FMT_BIT] && !fmt24_reg && time_reg.hour == RST_HOUR && !ldHour
    |=> time_reg.hour == BCD_ZERO && clockFormat24h)
    else $error("12H did not become 00H in 24-hour format");

  a_week_with_day: assert property (
    hourCarry && !ldDay && !ldWeek |=> time_reg.day != $past(time_reg.day)
    && time_reg.week != $past(time_reg.week))
    else $error("weekday and day did not step together");

  a_day_carry: assert property (
    hourCarry && time_reg.day == dayMax && !ldDay |=> dayCarry && time_reg.day == DAY_MIN)
    else $error("day wrap missing");
endmodule // rtc_tod

// File: rtc_pkg.sv
// Constants, types and helpers shared by the time-of-day counter chain.
// Assumes a single 100 MHz clock and an AXI4-Lite master with 32-bit data.
// Functional notes
// - Seconds count BCD 00..59, advancing on each 16-bit prescaler overflow.
// - Counter writes go to a buffer, reaching the counter within two clocks.
// - A seconds write clears the prescaler to zero.
// - Minutes count BCD 00..59, advancing on each seconds carry.
// - A write to minutes, hours or day beats a simultaneous carry.
// - Hours advance on each minutes carry, except a carry in the cycle of a format change, which the conversion beats.
// - Control bit 3 selects hour format: 0 is 12-hour, 1 is 24-hour.
// - In 12-hour format hour bit 5 marks afternoon.
// - 24-hour counts 00..23; 12-hour runs 12,01..11,32,21..31.
// - Changing the format bit converts the hours to the new encoding.
// - Reset gives hours 12H; switching to 24-hour then reads 00H.
// - Day wraps after 31, 30, 29 or 28 depending on month and leap year.
// - Weekday counts 0..6, advancing together with the day counter.
// - Reset gives seconds, minutes, weekday 00H and day 01H.
// - Hold acknowledge follows a hold request within one clock.
// - One overflow during hold is remembered, unless seconds were written; further ones in the same hold are lost.
// - BCD years divisible by four count as leap years.
package rtc_pkg;
  localparam logic [19:0] IDX_CTL = 20'hfff90;
  localparam logic [19:0] IDX_HOLD = 20'hfff91;
  localparam logic [19:0] IDX_SEC = 20'hfff92;
  localparam logic [19:0] IDX_MIN = 20'hfff93;
  localparam logic [19:0] IDX_HOUR = 20'hfff94;
  localparam logic [19:0] IDX_WEEK = 20'hfff95;
  localparam logic [19:0] IDX_DAY = 20'hfff96;
  localparam int CTL_FMT_BIT = 3;
  localparam int CTL_RUN_BIT = 7;
  localparam int HOLD_REQ_BIT = 0;
  localparam int HOLD_ACK_BIT = 1;
  localparam int PM_BIT = 5;
  localparam logic [7:0] PM_MASK = 8'h20;
  localparam logic [7:0] RST_SEC = 8'h00;
  localparam logic [7:0] RST_MIN = 8'h00;
  localparam logic [7:0] RST_HOUR = 8'h12;
  localparam logic [7:0] RST_WEEK = 8'h00;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] WEEK_MAX = 8'h06;
  localparam logic [7:0] H24_MAX = 8'h23;
  localparam logic [7:0] DAY_MIN = 8'h01;
  localparam logic [7:0] DAY_31 = 8'h31;
  localparam logic [7:0] DAY_30 = 8'h30;
  localparam logic [7:0] DAY_29 = 8'h29;
  localparam logic [7:0] DAY_28 = 8'h28;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [3:0] LEAP_EVEN_A = 4'h0;
  localparam logic [3:0] LEAP_EVEN_B = 4'h4;
  localparam logic [3:0] LEAP_EVEN_C = 4'h8;
  localparam logic [3:0] LEAP_ODD_A = 4'h2;
  localparam logic [3:0] LEAP_ODD_B = 4'h6;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [6:0] BCD_RADIX = 7'h0a;
  localparam logic [6:0] HOURS_HALF = 7'h0c;
  localparam logic [6:0] HOURS_LAST = 7'h17;
  localparam logic [15:0] PRESC_MAX = 16'hffff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] week;
    logic [7:0] day;
  } rtc_time_s;

  typedef enum logic [2:0] {
    SEL_SEC = 3'b000,
    SEL_MIN = 3'b001,
    SEL_HOUR = 3'b010,
    SEL_WEEK = 3'b011,
    SEL_DAY = 3'b100,
    SEL_CTL = 3'b101,
    SEL_HOLD = 3'b110,
    SEL_NONE = 3'b111
  } rtc_sel_e;

  function automatic logic [31:0] rtcByteAddr(input logic [19:0] idx);
    return {10'h000, idx, 2'h0};
  endfunction

  function automatic rtc_sel_e rtcSel(input logic [31:0] addr);
    if (addr == rtcByteAddr(IDX_SEC)) return SEL_SEC;
    if (addr == rtcByteAddr(IDX_MIN)) return SEL_MIN;
    if (addr == rtcByteAddr(IDX_HOUR)) return SEL_HOUR;
    if (addr == rtcByteAddr(IDX_WEEK)) return SEL_WEEK;
    if (addr == rtcByteAddr(IDX_DAY)) return SEL_DAY;
    if (addr == rtcByteAddr(IDX_CTL)) return SEL_CTL;
    if (addr == rtcByteAddr(IDX_HOLD)) return SEL_HOLD;
    return SEL_NONE;
  endfunction

  function automatic logic [6:0] bcd2bin(input logic [7:0] b);
    return 7'(7'(b[7:4]) * BCD_RADIX) + 7'(b[3:0]);
  endfunction

  function automatic logic [7:0] bin2bcd(input logic [6:0] v);
    return {4'(v / BCD_RADIX), 4'(v % BCD_RADIX)};
  endfunction

  // Binary 0..23 to the 12-hour code with the afternoon bit
  function automatic logic [7:0] rtcTo12(input logic [6:0] v);
    logic pm;
    logic [6:0] r;
    pm = (v >= HOURS_HALF);
    r = pm ? 7'(v - HOURS_HALF) : v;
    if (r == 7'h00) r = HOURS_HALF;
    return bin2bcd(r) | (pm ? PM_MASK : BCD_ZERO);
  endfunction

  function automatic logic [7:0] rtcDayMax(input logic [7:0] month, input logic [7:0] year);
    logic leap;
    leap = year[4] ? (year[3:0] == LEAP_ODD_A || year[3:0] == LEAP_ODD_B)
                   : (year[3:0] == LEAP_EVEN_A || year[3:0] == LEAP_EVEN_B
                      || year[3:0] == LEAP_EVEN_C);
    if (month == MON_FEB) return leap ? DAY_29 : DAY_28;
    if (month == MON_APR || month == MON_JUN || month == MON_SEP || month == MON_NOV)
      return DAY_30;
    return DAY_31;
  endfunction
endpackage

// File: rtc_bcd_step.sv
// One BCD counter step: the value after an increment and the wrap flag.
// Assumes the input already lies between the bounds given.
`timescale 1ns/1ps
module rtc_bcd_step (
  input logic [7:0] valIn,   // Present BCD value
  input logic [7:0] maxVal,  // Last value before wrap
  input logic [7:0] minVal,  // Value after wrap
  output logic [7:0] valNext, // Incremented value
  output logic atMax         // Value sits at its maximum
);
  import rtc_pkg::*;
  always_comb begin
    atMax = (valIn == maxVal);
    if (atMax) begin
      valNext = minVal;
    end else if (valIn[3:0] == BCD_NINE) begin
      valNext = {4'(valIn[7:4] + 4'h1), 4'h0};
    end else begin
      valNext = {valIn[7:4], 4'(valIn[3:0] + 4'h1)};
    end
  end
endmodule // rtc_bcd_step

// File: rtc_hour_conv.sv
// Hour counter arithmetic for both formats: conversion and increment.
// Assumes a legal hour code for the format given.
`timescale 1ns/1ps
module rtc_hour_conv (
  input logic [7:0] hourIn,  // Present hour code
  input logic fmt24,         // Format that hourIn is coded in
  output logic [7:0] as24,   // Same hour in 24-hour code
  output logic [7:0] as12,   // Same hour in 12-hour code
  output logic [7:0] hourNext, // Next hour in the current format
  output logic atLast        // Last hour of the day
);
  import rtc_pkg::*;
  logic [6:0] raw;
  logic [6:0] b24;
  logic [6:0] n24;
  always_comb begin
    raw = bcd2bin({3'h0, hourIn[4:0]});
    if (fmt24) begin
      b24 = bcd2bin(hourIn);
    end else if (raw == HOURS_HALF) begin
      b24 = hourIn[PM_BIT] ? HOURS_HALF : 7'h00;
    end else begin
      b24 = hourIn[PM_BIT] ? 7'(raw + HOURS_HALF) : raw;
    end
    atLast = (b24 == HOURS_LAST);
    n24 = atLast ? 7'h00 : 7'(b24 + 7'h01);
    as24 = bin2bcd(b24);
    as12 = rtcTo12(b24);
    hourNext = fmt24 ? bin2bcd(n24) : rtcTo12(n24);
  end
endmodule // rtc_hour_conv

// File: test_rtc_tod.sv
// Self-checking bench for the time-of-day counter chain and its register slave.
// Assumes rtc_pkg and rtc_tod are compiled first; the bench acts as AXI4-Lite master.
`timescale 1ns/1ps
module test_rtc_tod;
  import rtc_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic [7:0] monthBcd = 8'h02;
  logic [7:0] yearBcd = 8'h01;
  logic awready, wready, bvalid, arready, rvalid, dayCarry;
  logic clockFormat24h, counterRunEnable, countHoldAck;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int error_cnt = 0;
  int n_tests = 0;

  rtc_tod u_rtc_tod (.mclk(mclk), .arst_n(arst_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .monthBcd(monthBcd), .yearBcd(yearBcd), .dayCarry(dayCarry),
    .clockFormat24h(clockFormat24h), .counterRunEnable(counterRunEnable),
    .countHoldAck(countHoldAck));

  always #5 mclk = ~mclk;

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic hang(input string name);
    error_cnt++;
    $display("[ERR] %s expected answer seen none", name);
    results();
  endtask

  function automatic logic [31:0] ba(input logic [19:0] idx);
    return {10'h000, idx, 2'h0};
  endfunction

  // Address and data offered together; each released once taken
  task automatic axiWr(input logic [19:0] idx, input logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= ba(idx);
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (i == 20) hang("bvalid");
  endtask

  task automatic axiRd(input logic [19:0] idx, output logic [31:0] d, output logic [1:0] r);
    int i;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= ba(idx);
    rready <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (i == 20) hang("rvalid");
  endtask

  task automatic wr(input logic [19:0] idx, input logic [31:0] d);
    logic [1:0] r;
    axiWr(idx, d, r);
    check("bresp", 32'(r), 32'(RESP_OKAY));
  endtask

  task automatic rdChk(input logic [19:0] idx, input string name, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axiRd(idx, d, r);
    check(name, d, exp);
    check("rresp", 32'(r), 32'(RESP_OKAY));
  endtask

  task automatic tReset();
    rdChk(IDX_SEC, "sec", 32'h00);
    rdChk(IDX_MIN, "min", 32'h00);
    rdChk(IDX_HOUR, "hour", 32'h12);
    rdChk(IDX_WEEK, "week", 32'h00);
    rdChk(IDX_DAY, "day", 32'h01);
    check("fmt", 32'(clockFormat24h), 32'h0);
    wr(IDX_CTL, 32'h08);
    rdChk(IDX_HOUR, "hour24", 32'h00);
    check("fmt", 32'(clockFormat24h), 32'h1);
  endtask

  // Six 12-hour codes against their 24-hour twins, converted both ways
  task automatic tFormat();
    logic [7:0] h12 [6] = '{8'h12, 8'h01, 8'h11, 8'h32, 8'h21, 8'h31};
    logic [7:0] h24 [6] = '{8'h00, 8'h01, 8'h11, 8'h12, 8'h13, 8'h23};
    for (int k = 0; k < 6; k++) begin
      wr(IDX_CTL, 32'h00);
      wr(IDX_HOUR, 32'(h12[k]));
      rdChk(IDX_HOUR, "hour12", 32'(h12[k]));
      wr(IDX_CTL, 32'h08);
      rdChk(IDX_HOUR, "to24", 32'(h24[k]));
      wr(IDX_CTL, 32'h00);
      rdChk(IDX_HOUR, "to12", 32'(h12[k]));
    end
  endtask

  task automatic tUnmapped();
    logic [31:0] d;
    logic [1:0] r;
    axiWr(20'h00010, 32'h5a, r);
    check("bresp", 32'(r), 32'(RESP_SLVERR));
    axiRd(20'h00010, d, r);
    check("rresp", 32'(r), 32'(RESP_SLVERR));
    check("rdata", d, 32'h0);
    // Low byte disabled: answered, but nothing is stored
    wstrb <= 4'he;
    wr(IDX_MIN, 32'h33);
    wstrb <= 4'hf;
    rdChk(IDX_MIN, "minKeep", 32'h00);
  endtask

  // Last second of 28 February in a common year, 24-hour format
  task automatic tRollover();
    int n;
    wr(IDX_CTL, 32'h08);
    wr(IDX_HOUR, 32'h23);
    wr(IDX_MIN, 32'h59);
    wr(IDX_DAY, 32'h28);
    wr(IDX_WEEK, 32'h06);
    wr(IDX_SEC, 32'h59);
    wr(IDX_CTL, 32'h88);
    check("run", 32'(counterRunEnable), 32'h1);
    for (n = 0; n < 70000 && dayCarry !== 1'b1; n++) @(posedge mclk);
    if (n == 70000) hang("dayCarry");
    check("tick", 32'(n >= 65530 && n <= 65545), 32'h1);
    @(posedge mclk);
    check("pulse", 32'(dayCarry), 32'h0);
    wr(IDX_HOLD, 32'h01);
    @(posedge mclk);
    check("ack", 32'(countHoldAck), 32'h1);
    rdChk(IDX_HOLD, "hold", 32'h03);
    rdChk(IDX_SEC, "sec", 32'h00);
    rdChk(IDX_MIN, "min", 32'h00);
    rdChk(IDX_HOUR, "hour", 32'h00);
    rdChk(IDX_DAY, "day", 32'h01);
    rdChk(IDX_WEEK, "week", 32'h00);
    wr(IDX_HOLD, 32'h00);
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    tReset();
    tFormat();
    tUnmapped();
    tRollover();
    results();
  end
endmodule // test_rtc_tod
